// [pkg/vac_pkg.sv]
/*
  Package of the attribute controller: port addresses, register indices, field positions, reset values and the
  bus and pixel structs.
  Assumes one system clock and a host that issues one single-cycle read or write strobe at a time.
*/
// Operation
// - one shared port writes index and data
// - separate read port returns indexed register
// - every shared-port write toggles index/data flip-flop
// - status register read forces index state
// - data-port reads leave flip-flop unchanged
// - index bits 7:6 zero; bit5 locks palette
// - five-bit index selects registers 00h-14h
// - palette entries six bits, upper zero
// - color select supplies P7:6, optionally P5:4
// - mode bit6 bypasses palette, packs nibbles
// - mode bit5 limits panning to upper region
// - mode bit3 selects blink or background intensity
// - blink rate divides vertical sync
// - mode bit2 ninth pixel repeats eighth
// - mode bit1 mono attributes; bit4 zero
// - mode bit0 selects text or graphics
// - border color output during blanking
// - status mux picks palette bits for status
// - plane enable bits gate colour planes
package vac_pkg;

  // ------------------------------------------------------------------
  // Port addresses
  // ------------------------------------------------------------------
  localparam logic [15:0] VAC_ADDR_SHARED    = 16'h03C0;
  localparam logic [15:0] VAC_ADDR_DATA_RD   = 16'h03C1;
  localparam logic [15:0] VAC_ADDR_STAT_MONO = 16'h03BA;
  localparam logic [15:0] VAC_ADDR_STAT_CLR  = 16'h03DA;

  // ------------------------------------------------------------------
  // Register indices and fields
  // ------------------------------------------------------------------
  localparam logic [4:0] VAC_IDX_PAL_LAST = 5'h0F;
  localparam logic [4:0] VAC_IDX_MODE     = 5'h10;
  localparam logic [4:0] VAC_IDX_BORDER   = 5'h11;
  localparam logic [4:0] VAC_IDX_PLANE    = 5'h12;
  localparam logic [4:0] VAC_IDX_PAN      = 5'h13;
  localparam logic [4:0] VAC_IDX_CSEL     = 5'h14;
  localparam int VAC_IX_VIDEN  = 5;
  localparam int VAC_MC_P54SEL = 7;
  localparam int VAC_MC_PIX8   = 6;
  localparam int VAC_MC_PANCMP = 5;
  localparam int VAC_MC_RSVD   = 4;
  localparam int VAC_MC_BLINK  = 3;
  localparam int VAC_MC_LINEGR = 2;
  localparam int VAC_MC_MONO   = 1;
  localparam int VAC_MC_GRAPH  = 0;
  localparam logic [1:0] VAC_MUX_P20 = 2'h0;
  localparam logic [1:0] VAC_MUX_P54 = 2'h1;
  localparam logic [1:0] VAC_MUX_P31 = 2'h2;
  localparam logic [7:0] VAC_RST_BYTE = 8'h00;
  localparam logic [7:0] VAC_LINE_LO  = 8'hB0;
  localparam logic [7:0] VAC_LINE_HI  = 8'hDF;
  localparam int VAC_PAL_ENTRIES = 16;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        mono_emul;
  } vac_bus_t;

  typedef struct packed {
    logic       blank;
    logic       upper_region;
    logic       ninth_pixel;
    logic [3:0] planes;
    logic [7:0] attr;
    logic [7:0] char_code;
    logic       fg;
    logic [3:0] pan;
  } vac_pix_t;

endpackage : vac_pkg

// [design/vac_palette_mem.sv]
/*
  Sixteen-entry palette store with one write port and two registered read ports.
  Assumes the caller keeps write and read indices in range.
*/
`timescale 1ns/1ps
module vac_palette_mem #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  // Write port
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  // Read ports
  input  wire logic [$clog2(DEPTH)-1:0] raddr_a,
  output logic      [WIDTH-1:0]         rdata_a,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_b,
  output logic      [WIDTH-1:0]         rdata_b
);
  import vac_pkg::*;

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("vac_palette_mem: bad size");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];

  // The store has no reset; only the read registers do.
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem_q[raddr_a];
      rdata_b <= mem_q[raddr_b];
    end
  end
endmodule : vac_palette_mem

// [design/vac_blink_div.sv]
/*
  Blink divider: counts vertical sync pulses and toggles the blink phase.
  Assumes vsync_pulse is a one-cycle pulse per frame.
*/
`timescale 1ns/1ps
module vac_blink_div #(
  parameter int CW = 8
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset,
  // Control
  input  wire logic          vsync_pulse,
  input  wire logic [CW-1:0] rate,
  // Phase
  output logic               phase
);
  import vac_pkg::*;

  initial begin
    if (CW < 1) $error("vac_blink_div: bad width");
  end

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      phase <= 1'b0;
    end else if (vsync_pulse) begin
      if (cnt_q >= rate) begin
        cnt_q <= '0;
        phase <= ~phase;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end
endmodule : vac_blink_div

// [design/vac_attr_ctrl.sv]
/*
  Attribute controller: register bank on the host ports and the per-pixel attribute path.
  Assumes the host gives one-cycle rd/wr strobes and the pixel feed presents one pixel each
  dot enable; the status read port and misc emulation bit come from the surrounding device.
*/
`timescale 1ns/1ps
module vac_attr_ctrl #(
  parameter int BLINK_W = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Host access
  input  vac_pkg::vac_bus_t     bus,
  output logic [7:0]            rdata,
  output logic                  rvalid,
  // Pixel feed
  input  wire logic             dot_en,
  input  vac_pkg::vac_pix_t     pix,
  input  wire logic             vsync_pulse,
  input  wire logic [BLINK_W-1:0] blink_rate_control,
  // Video out
  output logic [7:0]            video,
  output logic                  video_valid,
  output logic [1:0]            status_bits,
  output logic                  pan_active,
  output logic [3:0]            pan_amount
);
  import vac_pkg::*;

  initial begin
    if (BLINK_W < 1) $error("vac_attr_ctrl: bad blink width");
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       data_phase;
    logic       vid_en;
    logic [4:0] index;
    logic [7:0] mode;
    logic [7:0] border;
    logic [7:0] plane;
    logic [3:0] pan;
    logic [3:0] csel;
    logic [7:0] rdata;
    logic [7:0] rd_hold;
    logic       rvalid;
    logic [7:0] video;
    logic       video_valid;
    logic [1:0] status;
    logic       pan_active;
    logic [3:0] pan_amount;
    logic       half;
    logic [3:0] nib;
    logic       rd_pend;
    logic       pal_pend;
    logic [1:0] pix_pend;
  } vac_state_t;

  vac_state_t s_q;
  vac_state_t s_d;

  logic       pal_we;
  logic [5:0] pal_rd;
  logic [5:0] pal_px;
  logic       blink_phase;
  logic [3:0] color;
  logic [7:0] pal_byte;
  logic       is_shared_wr;
  logic       is_stat_rd;
  logic       is_data_rd;

  function automatic logic [1:0] vac_mux(input logic [1:0] sel, input logic [7:0] p);
    case (sel)
      VAC_MUX_P20: vac_mux = {p[2], p[0]};
      VAC_MUX_P54: vac_mux = {p[5], p[4]};
      VAC_MUX_P31: vac_mux = {p[3], p[1]};
      default:     vac_mux = {p[7], p[6]};
    endcase
  endfunction : vac_mux

  function automatic logic [7:0] vac_map(input logic [5:0] e, input logic [7:0] m, input logic [3:0] c);
    vac_map = {c[3:2], m[VAC_MC_P54SEL] ? c[1:0] : e[5:4], e[3:0]};
  endfunction : vac_map

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  always_comb begin
    is_shared_wr = bus.wr && bus.addr == VAC_ADDR_SHARED;
    is_data_rd   = bus.rd && bus.addr == VAC_ADDR_DATA_RD;
    is_stat_rd   = bus.rd && bus.addr == (bus.mono_emul ? VAC_ADDR_STAT_MONO : VAC_ADDR_STAT_CLR);
    pal_we       = is_shared_wr && s_q.data_phase && !s_q.vid_en && s_q.index <= VAC_IDX_PAL_LAST;
  end

  vac_palette_mem #(.WIDTH(6), .DEPTH(VAC_PAL_ENTRIES)) u_pal (
    .clk_sys (clk_sys),
    .reset   (reset),
    .we      (pal_we),
    .waddr   (s_q.index[3:0]),
    .wdata   (bus.wdata[5:0]),
    .raddr_a (s_q.index[3:0]),
    .rdata_a (pal_rd),
    .raddr_b (color),
    .rdata_b (pal_px)
  );

  vac_blink_div #(.CW(BLINK_W)) u_blink (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .vsync_pulse (vsync_pulse),
    .rate        (blink_rate_control),
    .phase       (blink_phase)
  );

  // Pixel stage one: choose the colour nibble; the palette lookup lands a cycle later.
  always_comb begin
    logic [3:0] fg_c;
    logic [3:0] bg_c;
    logic       blink_bit;
    logic       dup;
    fg_c = '0;
    bg_c = '0;
    blink_bit = 1'b0;
    dup = 1'b0;
    if (!pix.blank) begin
      if (!s_q.mode[VAC_MC_GRAPH]) begin
        fg_c = pix.attr[3:0];
        bg_c = s_q.mode[VAC_MC_BLINK] ? {1'b0, pix.attr[6:4]} : pix.attr[7:4];
        blink_bit = s_q.mode[VAC_MC_BLINK] && pix.attr[7] && blink_phase;
        if (s_q.mode[VAC_MC_MONO]) begin
          fg_c = {pix.attr[3], 3'h0} | {1'b0, {3{pix.attr[0]}}};
          bg_c = {bg_c[3], 3'h0} | {1'b0, {3{pix.attr[6:4] == 3'h7}}};
        end
        dup = s_q.mode[VAC_MC_LINEGR] && pix.char_code >= VAC_LINE_LO
              && pix.char_code <= VAC_LINE_HI;
        if (pix.ninth_pixel && !dup) begin
          color = bg_c;
        end else begin
          color = (pix.fg && !blink_bit) ? fg_c : bg_c;
        end
      end else begin
        color = pix.planes;
        if (s_q.mode[VAC_MC_BLINK] && blink_phase) begin
          color = {1'b0, pix.planes[2:0]};
        end
      end
      color = color & s_q.plane[3:0];
    end else begin
      color = '0;
    end
  end

  always_comb begin
    pal_byte = vac_map(pal_px, s_q.mode, s_q.csel);
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.video_valid = 1'b0;
    s_d.rd_pend = 1'b0;
    s_d.pal_pend = 1'b0;
    if (is_shared_wr) begin
      s_d.data_phase = ~s_q.data_phase;
      if (!s_q.data_phase) begin
        s_d.vid_en = bus.wdata[VAC_IX_VIDEN];
        s_d.index  = bus.wdata[4:0];
      end else begin
        case (s_q.index)
          VAC_IDX_MODE:   s_d.mode   = bus.wdata & ~(8'h01 << VAC_MC_RSVD);
          VAC_IDX_BORDER: s_d.border = bus.wdata;
          VAC_IDX_PLANE:  s_d.plane  = {2'h0, bus.wdata[5:0]};
          VAC_IDX_PAN:    s_d.pan    = bus.wdata[3:0];
          VAC_IDX_CSEL:   s_d.csel   = bus.wdata[3:0];
          default:        s_d.index  = s_q.index;
        endcase
      end
    end else if (is_stat_rd) begin
      s_d.data_phase = 1'b0;
      s_d.rdata  = {2'h0, s_q.status, 4'h0};
      s_d.rvalid = 1'b1;
    end
    if (bus.rd && bus.addr == VAC_ADDR_SHARED) begin
      s_d.rdata  = {2'h0, s_q.vid_en, s_q.index};
      s_d.rvalid = 1'b1;
    end
    if (is_data_rd) begin
      s_d.rd_pend = 1'b1;
      s_d.pal_pend = s_q.index <= VAC_IDX_PAL_LAST;
      case (s_q.index)
        VAC_IDX_MODE:   s_d.rd_hold = s_q.mode;
        VAC_IDX_BORDER: s_d.rd_hold = s_q.border;
        VAC_IDX_PLANE:  s_d.rd_hold = s_q.plane;
        VAC_IDX_PAN:    s_d.rd_hold = {4'h0, s_q.pan};
        VAC_IDX_CSEL:   s_d.rd_hold = {4'h0, s_q.csel};
        default:        s_d.rd_hold = VAC_RST_BYTE;
      endcase
    end
    // Palette read data arrive from the store one cycle after the strobe.
    // Register values wait in a holding byte, so rdata only ever moves together with rvalid.
    if (s_q.rd_pend) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = s_q.rd_hold;
      if (s_q.pal_pend) begin
        s_d.rdata = s_q.vid_en ? VAC_RST_BYTE : {2'h0, pal_rd};
      end
    end
    s_d.pix_pend = {s_q.pix_pend[0], dot_en};
    s_d.pan_amount = s_q.pan;
    s_d.pan_active = !s_q.mode[VAC_MC_PANCMP] || pix.upper_region;
    if (s_q.pix_pend[0]) begin
      s_d.status = vac_mux(s_q.plane[5:4], pal_byte);
      if (pix.blank) begin
        s_d.video = s_q.border;
        s_d.video_valid = 1'b1;
        s_d.half = 1'b0;
      end else if (s_q.mode[VAC_MC_PIX8]) begin
        s_d.half = ~s_q.half;
        if (!s_q.half) begin
          s_d.nib = pix.planes & s_q.plane[3:0];
        end else begin
          s_d.video = {s_q.nib, pix.planes & s_q.plane[3:0]};
          s_d.video_valid = 1'b1;
        end
      end else begin
        s_d.video = {2'h0, pal_byte[5:0]};
        s_d.video[7:6] = pal_byte[7:6];
        s_d.video_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    rdata       = s_q.rdata;
    rvalid      = s_q.rvalid;
    video       = s_q.video;
    video_valid = s_q.video_valid;
    status_bits = s_q.status;
    pan_active  = s_q.pan_active;
    pan_amount  = s_q.pan_amount;
  end
endmodule : vac_attr_ctrl

// [dv/vac_chk.sv]
/*
  Port checker of the attribute controller.
  Assumes one clock domain and the read latencies of the register ports.
*/
`timescale 1ns/1ps
module vac_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  // Host side
  input vac_pkg::vac_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  // Pixel side
  input wire logic       dot_en,
  input wire logic       video_valid
);
  import vac_pkg::*;
  wire [15:0] a  = bus.addr;
  wire [15:0] st = bus.mono_emul ? VAC_ADDR_STAT_MONO : VAC_ADDR_STAT_CLR;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----
  // Assertions
  // ----
  chk_index_read: assert property (bus.rd && a == VAC_ADDR_SHARED |=> rvalid && rdata[7:6] == 2'h0)
    else $error("index read answer wrong");
  chk_data_read: assert property (bus.rd && a == VAC_ADDR_DATA_RD |=> !rvalid ##1 rvalid)
    else $error("data read latency wrong");
  chk_status_ack: assert property (bus.rd && a == st |=> rvalid)
    else $error("status read not answered");
  chk_status_format: assert property (bus.rd && a == st |=> rdata[7:6] == 2'h0 && rdata[3:0] == 4'h0)
    else $error("status read format wrong");
  chk_quiet_bus: assert property (!(bus.rd && (a == VAC_ADDR_SHARED || a == VAC_ADDR_DATA_RD || a == st))
    && !$past(bus.rd) |=> !rvalid)
    else $error("answer without a mapped read");
  chk_rdata_hold: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved between reads");
  chk_rvalid_cause: assert property (rvalid |-> $past(bus.rd) || $past(bus.rd, 2))
    else $error("answer without a read");
  chk_video_latency: assert property (video_valid |-> $past(dot_en, 2))
    else $error("video without a dot two cycles before");
endmodule : vac_chk
bind vac_attr_ctrl vac_chk u_chk (.clk_sys(clk_sys), .reset(reset), .bus(bus), .rdata(rdata), .rvalid(rvalid),
  .dot_en(dot_en), .video_valid(video_valid));

// [dv/vac_host_model.sv]
/*
  Host processor model: single-cycle reads and writes on the attribute ports.
  Assumes one caller at a time; released lines show inverted values.
*/
`timescale 1ns/1ps
module vac_host_model (
  // Clock
  input wire logic       clk_sys,
  // Bus
  output vac_pkg::vac_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic       rvalid
);
  import vac_pkg::*;
  // ----
  // Access tasks
  // ----
  initial bus = '0;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    bus = {2'b01, a, d, bus.mono_emul};
    @(posedge clk_sys) #1;
    bus = {2'b00, ~a, ~d, bus.mono_emul};
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
    int n;
    @(posedge clk_sys) #1;
    bus = {2'b10, a, ~bus.wdata, bus.mono_emul};
    @(posedge clk_sys) #1;
    bus = {2'b00, ~a, bus.wdata, bus.mono_emul};
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk_sys) #1;
      n++;
    end
    ok = rvalid === 1'b1;
    d = rdata;
  endtask : rd
  // Moves the status port, so a stale address must then stay unanswered.
  task automatic emul(input logic m);
    @(posedge clk_sys) #1;
    bus.mono_emul = m;
  endtask : emul
endmodule : vac_host_model

// [dv/vac_attr_ctrl_tb.sv]
/*
  Self-checking bench of the attribute controller.
  Assumes the host model drives the bus; the bench drives the pixel feed.
*/
`timescale 1ns/1ps
module vac_attr_ctrl_tb;
  import vac_pkg::*;
  // ----
  // Signals and tables
  // ----
  localparam logic [23:0] ROWS [8] = '{24'h00FF3F, 24'h0FA525, 24'h10FFEF, 24'h11C3C3, 24'h12FF3F,
                                       24'h13A707, 24'h14FF0F, 24'h15FF00};
  localparam logic [15:0] ST = 16'hC7CB;
  logic       clk_sys, reset, dot_en, rvalid, video_valid, pan_active, vsync_pulse;
  logic [7:0] rdata, video, blink_rate;
  logic [1:0] status_bits;
  logic [3:0] pan_amount;
  vac_bus_t   bus;
  vac_pix_t   pix;
  int         miscompares, cmp_count;
  vac_attr_ctrl DUT (.clk_sys(clk_sys), .reset(reset), .bus(bus), .rdata(rdata), .rvalid(rvalid), .dot_en(dot_en),
    .pix(pix), .vsync_pulse(vsync_pulse), .blink_rate_control(blink_rate), .video(video), .video_valid(video_valid),
    .status_bits(status_bits), .pan_active(pan_active), .pan_amount(pan_amount));
  vac_host_model HOST (.clk_sys(clk_sys), .bus(bus), .rdata(rdata), .rvalid(rvalid));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    HOST.rd(a, d, ok);
    if (!ok) begin
      miscompares++;
      test_done();
    end
    chk(d, exp);
  endtask : rd
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    HOST.wr(VAC_ADDR_SHARED, i);
    HOST.wr(VAC_ADDR_SHARED, d);
  endtask : wreg
  // The status read puts the port back in index phase after the odd index write.
  task automatic setup(input logic [7:0] plane, input logic [7:0] mode);
    logic [7:0] d;
    bit         ok;
    HOST.rd(VAC_ADDR_STAT_MONO, d, ok);
    wreg(8'h12, plane);
    wreg(8'h10, mode);
    HOST.wr(VAC_ADDR_SHARED, 8'h20);
  endtask : setup
  task automatic dot(input logic [3:0] pl, input logic b);
    @(posedge clk_sys) #1;
    dot_en = 1'b1;
    pix = '{blank: b, planes: pl, default: '0};
    @(posedge clk_sys) #1;
    dot_en = 1'b0;
  endtask : dot
  task automatic vid(input logic [7:0] exp);
    int n;
    n = 0;
    while (video_valid !== 1'b1 && n < 4) begin
      @(posedge clk_sys) #1;
      n++;
    end
    if (n == 4) begin
      miscompares++;
      test_done();
    end
    chk(video, exp);
  endtask : vid
  task automatic tdot(input logic [7:0] at, input logic [7:0] code, input logic ninth, input logic fgb,
                      input logic [7:0] exp);
    @(posedge clk_sys) #1;
    dot_en = 1'b1;
    pix = '{attr: at, char_code: code, ninth_pixel: ninth, fg: fgb, default: '0};
    @(posedge clk_sys) #1;
    dot_en = 1'b0;
    vid(exp);
  endtask : tdot
  task automatic vs;
    @(posedge clk_sys) #1;
    vsync_pulse = 1'b1;
    @(posedge clk_sys) #1;
    vsync_pulse = 1'b0;
  endtask : vs
  initial begin
    logic [7:0] d;
    bit         ok;
    reset = 1'b1;
    dot_en = 1'b0;
    pix = '0;
    vsync_pulse = 1'b0;
    blink_rate = 8'h01;
    miscompares = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk_sys);
    #1 reset = 1'b0;
    foreach (ROWS[i]) begin
      wreg(ROWS[i][23:16], ROWS[i][15:8]);
      rd(VAC_ADDR_DATA_RD, ROWS[i][7:0]);
    end
    chk({3'h0, pan_active, pan_amount}, 8'h07);
    pix.upper_region = 1'b1;
    @(posedge clk_sys) #1;
    chk({3'h0, pan_active, pan_amount}, 8'h17);
    pix = '0;
    $display("register table done");
    HOST.wr(VAC_ADDR_SHARED, 8'hD1);
    rd(VAC_ADDR_SHARED, 8'h11);
    rd(VAC_ADDR_DATA_RD, 8'hC3);
    rd(VAC_ADDR_DATA_RD, 8'hC3);
    HOST.wr(VAC_ADDR_SHARED, 8'h5A);
    rd(VAC_ADDR_DATA_RD, 8'h5A);
    for (int m = 0; m < 2; m++) begin
      HOST.wr(VAC_ADDR_SHARED, 8'h11);
      HOST.emul(m[0]);
      HOST.rd(m[0] ? VAC_ADDR_STAT_CLR : VAC_ADDR_STAT_MONO, d, ok);
      chk({7'h0, ok}, 8'h00);
      rd(m[0] ? VAC_ADDR_STAT_MONO : VAC_ADDR_STAT_CLR, 8'h00);
      wreg(8'h11, {7'h38, m[0]});
      rd(VAC_ADDR_DATA_RD, {7'h38, m[0]});
    end
    wreg(8'h20, 8'h11);
    rd(VAC_ADDR_DATA_RD, 8'h00);
    HOST.wr(VAC_ADDR_SHARED, 8'h00);
    rd(VAC_ADDR_DATA_RD, 8'h3F);
    HOST.wr(VAC_ADDR_SHARED, 8'h3F);
    $display("flip-flop and lock done");
    wreg(8'h14, 8'h0D);
    for (int k = 0; k < 8; k++) begin
      setup({2'h0, k[1:0], 4'hF}, {k[2], 7'h01});
      dot(4'hF, 1'b0);
      vid(k[2] ? 8'hD5 : 8'hE5);
      chk({6'h0, status_bits}, {6'h0, ST[2*k+:2]});
    end
    dot(4'hF, 1'b1);
    vid(8'h71);
    setup(8'h30, 8'h81);
    dot(4'hF, 1'b0);
    vid(8'hDF);
    setup(8'h0F, 8'h41);
    dot(4'hA, 1'b0);
    dot(4'h5, 1'b0);
    vid(8'hA5);
    $display("pixel path done");
    HOST.rd(VAC_ADDR_STAT_MONO, d, ok);
    wreg(8'h08, 8'h0A);
    setup(8'h0F, 8'h00);
    tdot(8'h0F, 8'h00, 1'b0, 1'b1, 8'hE5);
    tdot(8'h8F, 8'h00, 1'b0, 1'b0, 8'hCA);
    setup(8'h0F, 8'h04);
    tdot(8'h0F, 8'hDF, 1'b1, 1'b1, 8'hE5);
    tdot(8'h0F, 8'hE0, 1'b1, 1'b1, 8'hFF);
    setup(8'h0F, 8'h02);
    tdot(8'h08, 8'h00, 1'b0, 1'b1, 8'hCA);
    setup(8'h0F, 8'h08);
    vs();
    tdot(8'h8F, 8'h00, 1'b0, 1'b1, 8'hE5);
    vs();
    tdot(8'h8F, 8'h00, 1'b0, 1'b1, 8'hFF);
    setup(8'h0F, 8'h09);
    dot(4'h8, 1'b0);
    vid(8'hFF);
    $display("text path done");
    @(posedge clk_sys) #1;
    reset = 1'b1;
    @(posedge clk_sys) #1;
    reset = 1'b0;
    chk(video, 8'h00);
    chk({status_bits, 2'h0, pan_amount}, 8'h00);
    rd(VAC_ADDR_SHARED, 8'h00);
    wreg(8'h11, 8'h5A);
    rd(VAC_ADDR_DATA_RD, 8'h5A);
    $display("reset done");
    test_done();
  end
endmodule : vac_attr_ctrl_tb
